// [tb.sv]
// self-checking bench for the timer with shared scaler
`timescale 1ns/100ps
module tb;
    import tmrps_pkg::*;
    logic clk, resetn, run, regWrite, optionWrite, watchdogClearOp, watchdogRawTick;
    logic extCountInput, watchdogScaledTick;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, t1;
    logic [5:0] optionData;
    logic [3:0] instrPhase;
    int bad_count, comparisons, tickCount;

    tmrps_ext_src src (.run(run), .extPin(extCountInput));
    tmrps_timer DUT (.clk(clk), .resetn(resetn), .extCountInput(extCountInput),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .optionWrite(optionWrite), .optionData(optionData),
        .watchdogClearOp(watchdogClearOp), .watchdogRawTick(watchdogRawTick),
        .regRdData(regRdData), .watchdogScaledTick(watchdogScaledTick),
        .instrPhase(instrPhase));

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (watchdogScaledTick === 1'b1) tickCount++;
    end
    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        regWrData = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
    endtask
    task automatic opt(input logic [5:0] o);
        optionData = o;
        optionWrite = 1'b1;
        tick(1);
        optionWrite = 1'b0;
        tick(3);
    endtask
    task automatic wdClr;
        watchdogClearOp = 1'b1;
        tick(1);
        watchdogClearOp = 1'b0;
        tick(2);
    endtask
    task automatic rawTicks(input int n);
        repeat (n) begin
            watchdogRawTick = 1'b1;
            tick(1);
            watchdogRawTick = 1'b0;
            tick(3);
        end
    endtask
    // one toggle per 200 ns of run time, measured in clocks
    task automatic toggles(input int n);
        run = 1'b1;
        tick(4 * n - 2);
        run = 1'b0;
        tick(12);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, run, regWrite, optionWrite, watchdogClearOp, watchdogRawTick} = '0;
        regAddr = TMRPS_TIMER_COUNT_ADDR;
        regWrData = 8'h00;
        optionData = 6'h00;
        tickCount = 0;
        tick(8);
        check(regRdData, 8'h00);
        check({4'h0, instrPhase}, 8'h01);
        resetn = 1'b1;
        tick(20);
        // option resets to counter mode, so an idle pin leaves the count alone
        check(regRdData, TMRPS_TIMER_COUNT_RST);
        regAddr = 7'h02;
        wr(8'h77);
        tick(2);
        check(regRdData, TMRPS_READ_UNMAPPED);
        regAddr = TMRPS_TIMER_COUNT_ADDR;
        // timer mode, scaler parked on the watchdog
        opt(6'h0f);
        wr(8'hfd);
        tick(6);
        check(regRdData, 8'hfd);
        tick(6);
        t1 = regRdData;
        tick(16);
        check(regRdData - t1, 8'h04);
        // every timer ratio, window of two whole counts
        wdClr();
        for (int n = 0; n < 8; n++) begin
            opt(6'(n));
            wr(8'h00);
            tick(12);
            t1 = regRdData;
            tick(8 * (2 << n));
            check(regRdData - t1, 8'h02);
        end
        // raw tick passes unscaled while the timer owns the scaler
        tickCount = 0;
        rawTicks(16);
        tick(4);
        check(8'(tickCount), 8'h10);
        wdClr();
        wr(8'h00);
        for (int n = 0; n < 5; n++) begin
            opt(6'h08 | 6'(n));
            wdClr();
            tickCount = 0;
            rawTicks(16);
            tick(4);
            check(8'(tickCount), 8'(16 >> n));
        end
        // counter mode, rising then falling edge select
        for (int e = 0; e < 2; e++) begin
            opt(e ? 6'h38 : 6'h28);
            tick(8);
            t1 = regRdData;
            run = 1'b1;
            tick(2);
            run = 1'b0;
            check(regRdData, t1);
            tick(8);
            check(regRdData, t1 + 8'(1 - e));
            toggles(1);
            check(regRdData, t1 + 8'h01);
        end
        // counter mode through the scaler at 1:2
        wdClr();
        opt(6'h20);
        wr(8'h00);
        tick(12);
        toggles(16);
        check(regRdData, 8'h04);
        // reset in mid-run clears count
        resetn = 1'b0;
        tick(2);
        check(regRdData, 8'h00);
        resetn = 1'b1;
        tick(3);
        check(regRdData, 8'h00);
        results();
    end
endmodule // tb

// [tmrps_ext_src.sv]
// model of the external count source driving the count pin
`timescale 1ns/100ps
// ------------------------------------------------------------
// count source
// ------------------------------------------------------------
module tmrps_ext_src (
    input wire logic run,
    output logic extPin
);
    // a driven pin: it stands still at its last level between frames
    initial begin
        extPin = 1'b0;
        forever begin
            wait (run === 1'b1);
            // half period of 200 ns keeps each level four clocks long
            extPin = ~extPin;
            #200;
        end
    end
endmodule // tmrps_ext_src

// [tmrps_pkg.sv]
// package: constants and types for the timer with shared scaler
package tmrps_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] TMRPS_TIMER_COUNT_ADDR = 7'h01;
    localparam logic [7:0] TMRPS_TIMER_COUNT_RST = 8'h00;
    localparam logic [5:0] TMRPS_OPTION_RST = 6'h3f;
    localparam logic [7:0] TMRPS_READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // option field positions
    // ------------------------------------------------------------
    localparam int TMRPS_SRC_SEL_BIT = 5;
    localparam int TMRPS_EDGE_SEL_BIT = 4;
    localparam int TMRPS_ASSIGN_BIT = 3;
    localparam int TMRPS_RATIO_LSB = 0;
    localparam int TMRPS_RATIO_W = 3;

    // ------------------------------------------------------------
    // scaler and timing
    // ------------------------------------------------------------
    localparam int TMRPS_SCALER_W = 8;
    localparam logic [7:0] TMRPS_SCALER_RST = 8'h00;
    localparam logic [1:0] TMRPS_INHIBIT_CYCLES = 2'h2;
    localparam int TMRPS_CLK_NS = 50;
    localparam int TMRPS_PHASES_PER_CYCLE = 4;
    localparam int TMRPS_INSTR_NS = TMRPS_CLK_NS * TMRPS_PHASES_PER_CYCLE;

    // ------------------------------------------------------------
    // internal phase clocks, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_FIRST = 4'h1,
        PH_SECOND = 4'h2,
        PH_THIRD = 4'h4,
        PH_FOURTH = 4'h8
    } tmrps_phase_t;
endpackage

// [tmrps_timer.sv]
// module: 8-bit timer/counter with scaler shared with the watchdog
// How it works
// - source select 0, no scaler: count advances once per instruction cycle.
// - after a count write, two instruction cycles pass without counting.
// - source select 1: count advances on edges of the external input.
// - edge select 0 counts rising edges, 1 counts falling edges.
// - one 8-bit scaler serves either the timer or the watchdog, never both.
// - assignment bit 0 gives scaler to timer, 1 to watchdog.
// - timer ratios run in powers of two from 1:2 to 1:256.
// - software can neither read nor write the scaler.
// - any count write clears the scaler while timer owns it.
// - watchdog clear clears the scaler while watchdog owns it.
// - reset forces the scaler to zero.
// - scaler output is sampled in the second and fourth phases.
// - scaled input period at least four periods over the ratio.
// - count advances two to five periods after an input edge.
// - the count register is 8-bit read/write at data address 01h.
`timescale 1ns/100ps
module tmrps_timer
    import tmrps_pkg::*;
#(
    parameter int SCALER_W = TMRPS_SCALER_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic extCountInput,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic optionWrite,
    input wire logic [5:0] optionData,
    input wire logic watchdogClearOp,
    input wire logic watchdogRawTick,
    output logic [7:0] regRdData,
    output logic watchdogScaledTick,
    output logic [3:0] instrPhase
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic scalerBit(input logic [SCALER_W-1:0] s,
                                       input logic [3:0] idx);
        logic r;
        r = 1'b0;
        for (int i = 0; i < SCALER_W; i++) begin
            if (idx == 4'(i)) begin
                r = s[i];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tmrps_phase_t phase_r, phase_nxt;
    logic [5:0] option_r;
    logic [7:0] timerCount_r, timerCount_nxt;
    logic [SCALER_W-1:0] scaler_r, scaler_nxt;
    logic [1:0] inhibit_r;
    logic extSync1_r, extSync2_r, extLvlPrev_r;
    logic smp_r;
    logic wdtBitPrev_r;
    logic [7:0] rdData_r;
    logic wdtTick_r;

    logic srcSel, edgeSel, toWdt;
    logic [2:0] ratio;
    logic cycleEnd, samplePhase;
    logic extLevel, extEdge, srcPulse;
    logic timerWrite, scalerClr, scalerInc;
    logic timerScaled, rawOut, sampledRise, incReq, incOk;
    logic wdtBit, wdtBitRise;

    // level seen just after reset: sync flops clear, edge select comes up set;
    // starting the edge pick there keeps reset from posing as a count edge
    localparam logic LVL_RST = TMRPS_OPTION_RST[TMRPS_EDGE_SEL_BIT];

    assign srcSel = option_r[TMRPS_SRC_SEL_BIT];
    assign edgeSel = option_r[TMRPS_EDGE_SEL_BIT];
    assign toWdt = option_r[TMRPS_ASSIGN_BIT];
    assign ratio = option_r[TMRPS_RATIO_LSB +: TMRPS_RATIO_W];
    assign cycleEnd = (phase_r == PH_FOURTH);
    assign samplePhase = (phase_r == PH_SECOND) || (phase_r == PH_FOURTH);

    // ------------------------------------------------------------
    // internal phase clocks
    // ------------------------------------------------------------
    always_comb begin
        unique case (phase_r)
            PH_FIRST: phase_nxt = PH_SECOND;
            PH_SECOND: phase_nxt = PH_THIRD;
            PH_THIRD: phase_nxt = PH_FOURTH;
            PH_FOURTH: phase_nxt = PH_FIRST;
            default: phase_nxt = PH_FIRST;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= PH_FIRST;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // ------------------------------------------------------------
    // option register, write-only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            option_r <= TMRPS_OPTION_RST;
        end else if (optionWrite) begin
            option_r <= optionData;
        end
    end

    // ------------------------------------------------------------
    // external input: two-stage sync, then edge pick
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extSync1_r <= 1'b0;
            extSync2_r <= 1'b0;
            extLvlPrev_r <= LVL_RST;
        end else begin
            extSync1_r <= extCountInput;
            extSync2_r <= extSync1_r;
            extLvlPrev_r <= extLevel;
        end
    end

    // inverting for falling edges turns both choices into a rising edge
    assign extLevel = extSync2_r ^ edgeSel;
    assign extEdge = extLevel & ~extLvlPrev_r;
    assign srcPulse = srcSel ? extEdge : cycleEnd;

    // ------------------------------------------------------------
    // shared scaler, no software path in or out
    // ------------------------------------------------------------
    assign timerWrite = regWrite && (regAddr == TMRPS_TIMER_COUNT_ADDR);
    assign scalerClr = (timerWrite && !toWdt)
        || (watchdogClearOp && toWdt);
    // clocked by the sync'd edge, not a true ripple chain: keeps one domain
    assign scalerInc = toWdt ? watchdogRawTick : srcPulse;

    always_comb begin
        scaler_nxt = scaler_r;
        if (scalerClr) begin
            scaler_nxt = TMRPS_SCALER_RST;
        end else if (scalerInc) begin
            scaler_nxt = scaler_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scaler_r <= TMRPS_SCALER_RST;
        end else begin
            scaler_r <= scaler_nxt;
        end
    end

    // ------------------------------------------------------------
    // timer source: scaler bit n rises once every 2^(n+1) counts
    // ------------------------------------------------------------
    assign timerScaled = !toWdt;
    assign rawOut = timerScaled ? scalerBit(scaler_r, {1'b0, ratio})
        : extLevel;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            smp_r <= LVL_RST; // watchdog owns scaler after reset: raw level is sampled
        end else if (samplePhase) begin
            smp_r <= rawOut;
        end
    end

    assign sampledRise = samplePhase && rawOut && !smp_r;
    assign incReq = (!srcSel && !timerScaled) ? cycleEnd : sampledRise;

    // ------------------------------------------------------------
    // write inhibit, counted in instruction cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inhibit_r <= 2'h0;
        end else if (timerWrite) begin
            inhibit_r <= TMRPS_INHIBIT_CYCLES;
        end else if (cycleEnd && inhibit_r != 2'h0) begin
            inhibit_r <= inhibit_r - 2'h1;
        end
    end

    assign incOk = incReq && (inhibit_r == 2'h0);

    // ------------------------------------------------------------
    // count register
    // ------------------------------------------------------------
    always_comb begin
        timerCount_nxt = timerCount_r;
        if (timerWrite) begin
            timerCount_nxt = regWrData;
        end else if (incOk) begin
            timerCount_nxt = timerCount_r + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerCount_r <= TMRPS_TIMER_COUNT_RST;
        end else begin
            timerCount_r <= timerCount_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= TMRPS_READ_UNMAPPED;
        end else if (regAddr == TMRPS_TIMER_COUNT_ADDR) begin
            rdData_r <= timerCount_r;
        end else begin
            rdData_r <= TMRPS_READ_UNMAPPED;
        end
    end

    assign regRdData = rdData_r;

    // ------------------------------------------------------------
    // watchdog postscaler output
    // ------------------------------------------------------------
    // code 0 means no division: raw tick passes straight through
    assign wdtBit = scalerBit(scaler_r, {1'b0, ratio} - 4'h1);
    assign wdtBitRise = wdtBit && !wdtBitPrev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdtBitPrev_r <= 1'b0;
            wdtTick_r <= 1'b0;
        end else begin
            wdtBitPrev_r <= wdtBit;
            if (!toWdt) begin
                wdtTick_r <= watchdogRawTick;
            end else if (ratio == 3'h0) begin
                wdtTick_r <= watchdogRawTick;
            end else begin
                wdtTick_r <= wdtBitRise;
            end
        end
    end

    assign watchdogScaledTick = wdtTick_r;
    assign instrPhase = phase_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_writeTimer;
        timerWrite && !toWdt;
    endsequence

    sequence s_quietAfterWrite;
        timerWrite ##1 (!timerWrite) [*7];
    endsequence

    sequence s_cleanEdge;
        srcSel && toWdt && extEdge && inhibit_r == 2'h0 && !timerWrite && !optionWrite;
    endsequence

    a_write_hold_count: assert property (
        timerWrite |=> timerCount_r == $past(regWrData)
    ) else $error("count write not taken");

    a_write_hold_value: assert property (
        s_quietAfterWrite |-> timerCount_r == $past(timerCount_r, 6)
    ) else $error("count moved during write inhibit");

    a_write_clr_scaler: assert property (
        s_writeTimer |=> scaler_r == TMRPS_SCALER_RST
    ) else $error("timer write did not clear scaler");

    a_wdt_clr_scaler: assert property (
        watchdogClearOp && toWdt |=> scaler_r == TMRPS_SCALER_RST
    ) else $error("watchdog clear did not clear scaler");

    a_scaler_owner: assert property (
        toWdt && !watchdogRawTick && !scalerClr |=> $stable(scaler_r)
    ) else $error("scaler moved without its owner");

    a_cycle_count_one: assert property (
        !srcSel && toWdt && cycleEnd && inhibit_r == 2'h0 && !timerWrite
        |=> timerCount_r == $past(timerCount_r) + 8'h01
    ) else $error("instruction cycle count missed");

    a_count_wraps: assert property (
        incOk && !timerWrite && timerCount_r == 8'hff |=> timerCount_r == 8'h00
    ) else $error("count did not wrap");

    a_sample_phases: assert property (
        $changed(smp_r) |-> $past(samplePhase)
    ) else $error("scaler output sampled outside phases");

    a_edge_to_count: assert property (
        s_cleanEdge ##1 !timerWrite |-> ##[0:1] timerCount_r != $past(timerCount_r)
    ) else $error("count did not follow synced edge in time");

    a_edge_advances: assert property (
        srcSel && toWdt && extEdge && inhibit_r == 2'h0 && !timerWrite
            ##1 (inhibit_r == 2'h0 && !timerWrite && !optionWrite) [*3]
        |-> timerCount_r != $past(timerCount_r, 3)
    ) else $error("count did not follow input edge");
endmodule // tmrps_timer
